/* File: logic/acr_map.vh */
/*
 * Constants of the converter computation register block: register
 * indices, field positions, reset values and mode codes.
 * Assumes an APB slave that places register index i at byte address 4*i.
 */
`ifndef ACR_MAP_VH
`define ACR_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACR_IDX_LTH    10'h08C
`define ACR_IDX_UTH    10'h08E
`define ACR_IDX_ERR    10'h090
`define ACR_IDX_STPT   10'h092
`define ACR_IDX_FLTR   10'h094
`define ACR_IDX_ACC    10'h096
`define ACR_IDX_CNT    10'h099
`define ACR_IDX_RPT    10'h09A
`define ACR_IDX_PREV   10'h09B
`define ACR_IDX_RES    10'h09D
`define ACR_IDX_CTRL   10'h0A0
`define ACR_IDX_STAT   10'h0A1

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ACR_CTRL_GO    0
`define ACR_CTRL_FMT   1
`define ACR_CTRL_PREVIOUS_SOURCE_SELECT  2
`define ACR_CTRL_MD_LO 4
`define ACR_CTRL_CRS_LO 8
`define ACR_CTRL_ERROR_SELECT_A_LO 12
`define ACR_CTRL_TMD_LO 16
`define ACR_CTRL_RST   19'h00000

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ACR_STAT_LOWER_THRESHOLD_FLAG  0
`define ACR_STAT_UPPER_THRESHOLD_FLAG  1
`define ACR_STAT_TIF   2

// ----------------------------------------------------------------
// computation modes
// ----------------------------------------------------------------
`define ACR_MD_BASIC   3'h0
`define ACR_MD_ACC     3'h1
`define ACR_MD_AVG     3'h2
`define ACR_MD_BURST   3'h3
`define ACR_MD_LPF     3'h4

// ----------------------------------------------------------------
// error calculation selects
// ----------------------------------------------------------------
`define ACR_ERROR_SELECT_A_RES_PREV  3'h0
`define ACR_ERROR_SELECT_A_RES_STPT  3'h1
`define ACR_ERROR_SELECT_A_RES_FLTR  3'h2
`define ACR_ERROR_SELECT_A_FLTR_STPT 3'h3
`define ACR_ERROR_SELECT_A_FLTR_PREV 3'h4

// ----------------------------------------------------------------
// threshold interrupt modes
// ----------------------------------------------------------------
`define ACR_TMD_NEVER   3'h0
`define ACR_TMD_LT_LO   3'h1
`define ACR_TMD_GE_LO   3'h2
`define ACR_TMD_INSIDE  3'h3
`define ACR_TMD_OUTSIDE 3'h4
`define ACR_TMD_LE_HI   3'h5
`define ACR_TMD_GT_HI   3'h6
`define ACR_TMD_ALWAYS  3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACR_THR_RST    16'h0000
`define ACR_PREVH_RST  8'h00

`endif

/* File: logic/acr_regs.v */
/*
 * Post-conversion computation registers of the converter: thresholds,
 * setpoint, error, filter, accumulator, repeat counter, previous and
 * current result, with an APB4 slave for software.
 * Assumes the conversion engine gives a one-cycle start pulse per
 * trigger and a one-cycle done pulse with the 12-bit sample, both
 * synchronous to pclk.
 */
`include "acr_map.vh"

module acr_regs #(
    parameter SAMPLE_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire conv_start,
    input wire conv_done,
    input wire [SAMPLE_W-1:0] conv_sample,
    output wire conv_go,
    output wire threshold_interrupt_flag
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // merge the strobed byte lanes of a write into a stored word
    // lanes with a clear strobe keep their old byte
    function [31:0] lane_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            lane_merge = old_v;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                    lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

    // arithmetic right shift of the accumulator to 16 bits
    // three select bits give a shift of zero to seven places
    function [15:0] acc_shift;
        input [17:0] acc_v;
        input [2:0] sh;
        reg signed [17:0] tmp;
        begin
            tmp = $signed(acc_v) >>> sh;
            acc_shift = tmp[15:0];
        end
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no reset marks a register left unknown after presetn on
    // purpose: presetn is a warm reset here, so software writes
    // them or runs a conversion before trusting them
    reg [15:0] lth_r; // lower threshold
    reg [15:0] uth_r; // upper threshold
    reg [15:0] stpt_r; // setpoint
    reg [15:0] err_r; // error, no reset
    reg [15:0] fltr_r; // filter output, no reset
    reg [17:0] acc_r; // accumulator, no reset
    reg [7:0] cnt_r; // repeat counter, no reset
    reg [7:0] rpt_r; // repeat setting
    reg [7:0] prevh_r; // previous result upper byte
    reg [7:0] prevl_r; // previous result lower byte, no reset
    reg [15:0] res_r; // sample result, no reset
    reg [18:0] ctrl_r; // control fields
    reg [2:0] stat_r; // threshold flags
    reg batch_new_r; // next sample starts a new batch

    // control field views
    wire go = ctrl_r[`ACR_CTRL_GO];
    wire fmt = ctrl_r[`ACR_CTRL_FMT];
    wire previous_source_select = ctrl_r[`ACR_CTRL_PREVIOUS_SOURCE_SELECT];
    wire [2:0] md = ctrl_r[`ACR_CTRL_MD_LO +: 3];
    wire [2:0] shift_select = ctrl_r[`ACR_CTRL_CRS_LO +: 3];
    wire [2:0] error_select_a = ctrl_r[`ACR_CTRL_ERROR_SELECT_A_LO +: 3];
    wire [2:0] threshold_mode_select = ctrl_r[`ACR_CTRL_TMD_LO +: 3];

    // stored words with the strobed lanes of pwdata merged in;
    // each register keeps only its own low bits of the word
    wire [31:0] lth_m = lane_merge({16'h0000, lth_r}, pwdata, pstrb);
    wire [31:0] uth_m = lane_merge({16'h0000, uth_r}, pwdata, pstrb);
    wire [31:0] stpt_m = lane_merge({16'h0000, stpt_r}, pwdata, pstrb);
    wire [31:0] ctrl_m = lane_merge({13'h0000, ctrl_r}, pwdata, pstrb);
    wire [31:0] res_m = lane_merge({16'h0000, res_r}, pwdata, pstrb);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // address bits 1:0 are ignored; every register is one word
    wire [9:0] idx = paddr[11:2]; // register index
    wire setup = psel & ~penable; // setup phase
    wire access = psel & penable; // access phase, zero wait
    wire wr_en = access & pwrite & ~pslverr; // write commit
    reg mapped; // index hits a register

    // which indices exist
    // anything else is refused with pslverr and reads as zero
    always @*
    begin
        case (idx)
            `ACR_IDX_LTH, `ACR_IDX_UTH, `ACR_IDX_ERR, `ACR_IDX_STPT,
            `ACR_IDX_FLTR, `ACR_IDX_ACC, `ACR_IDX_CNT, `ACR_IDX_RPT,
            `ACR_IDX_PREV, `ACR_IDX_RES, `ACR_IDX_CTRL, `ACR_IDX_STAT:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // zero wait states: the answer comes in the first access
    // cycle, so pready is never low while psel and penable stand
    assign pready = access;
    assign pslverr = access & ~mapped; // unmapped answers error

    // per-register write strobes
    // error, filter and previous get no strobe: a write there
    // only completes the transfer
    wire wr_lth = wr_en & (idx == `ACR_IDX_LTH);
    wire wr_uth = wr_en & (idx == `ACR_IDX_UTH);
    wire wr_stpt = wr_en & (idx == `ACR_IDX_STPT);
    wire wr_acc = wr_en & (idx == `ACR_IDX_ACC) & ~go;
    wire wr_cnt = wr_en & (idx == `ACR_IDX_CNT);
    wire wr_rpt = wr_en & (idx == `ACR_IDX_RPT);
    wire wr_res = wr_en & (idx == `ACR_IDX_RES);
    wire wr_ctrl = wr_en & (idx == `ACR_IDX_CTRL);
    wire wr_stat = wr_en & (idx == `ACR_IDX_STAT);

    // ------------------------------------------------------------
    // computation datapath
    // ------------------------------------------------------------
    // all of this settles in the cycle of conv_done and is stored
    // at its edge; nothing is held in a pipeline
    wire [15:0] samp16 = {{(16-SAMPLE_W){1'b0}}, conv_sample};
    wire [17:0] samp18 = {{(18-SAMPLE_W){1'b0}}, conv_sample};
    // aligned result word
    wire [15:0] res_algn = fmt ? samp16 :
        {conv_sample, {(16-SAMPLE_W){1'b0}}};
    wire rep_mode = (md == `ACR_MD_AVG) | (md == `ACR_MD_BURST) |
        (md == `ACR_MD_LPF);
    wire cnt_hit = (cnt_r == rpt_r);
    wire check = conv_done & (~rep_mode | cnt_hit);
    reg [17:0] acc_nxt; // accumulator after this sample
    reg [15:0] err_nxt; // error from this sample
    reg [17:0] acc_base; // accumulator before adding
    // signed on its own so the shift copies the sign bit; inside
    // the unsigned sum below it would shift in zeros
    wire signed [17:0] acc_decay = $signed(acc_r) >>> shift_select;
    wire [15:0] fltr_nxt = acc_shift(acc_nxt, shift_select);
    wire [15:0] prev_v = {prevh_r, prevl_r};

    // accumulate or filter the incoming sample
    // average and burst restart from zero at a new batch; basic
    // mode leaves the accumulator alone
    always @*
    begin
        acc_base = (batch_new_r & ((md == `ACR_MD_AVG) |
            (md == `ACR_MD_BURST))) ? 18'h00000 : acc_r;
        case (md)
            `ACR_MD_BASIC:
                acc_nxt = acc_r;
            `ACR_MD_LPF:
                // first-order low-pass: acc += x - acc/2^crs
                acc_nxt = acc_r + samp18 - acc_decay;
            default:
                acc_nxt = acc_base + samp18;
        endcase
    end

    // error calculation per select
    // the raw sample is taken right-aligned whatever the format,
    // so left alignment scales only a previous value taken from the result
    always @*
    begin
        case (error_select_a)
            `ACR_ERROR_SELECT_A_RES_PREV:
                err_nxt = samp16 - prev_v;
            `ACR_ERROR_SELECT_A_RES_STPT:
                err_nxt = samp16 - stpt_r;
            `ACR_ERROR_SELECT_A_RES_FLTR:
                err_nxt = samp16 - fltr_nxt;
            `ACR_ERROR_SELECT_A_FLTR_STPT:
                err_nxt = fltr_nxt - stpt_r;
            `ACR_ERROR_SELECT_A_FLTR_PREV:
                err_nxt = fltr_nxt - prev_v;
            default:
                err_nxt = samp16 - prev_v;
        endcase
    end

    // signed threshold tests
    // an unsigned compare would rank a negative error above
    // every positive threshold
    wire lt_lo = $signed(err_nxt) < $signed(lth_r);
    wire gt_hi = $signed(err_nxt) > $signed(uth_r);
    reg thr_met; // selected condition holds

    // pick the interrupting condition
    // lower and upper flags follow every check whatever the mode;
    // only the interrupt flag depends on it
    always @*
    begin
        case (threshold_mode_select)
            `ACR_TMD_NEVER: thr_met = 1'b0;
            `ACR_TMD_LT_LO: thr_met = lt_lo;
            `ACR_TMD_GE_LO: thr_met = ~lt_lo;
            `ACR_TMD_INSIDE: thr_met = ~lt_lo & ~gt_hi;
            `ACR_TMD_OUTSIDE: thr_met = lt_lo | gt_hi;
            `ACR_TMD_LE_HI: thr_met = ~gt_hi;
            `ACR_TMD_GT_HI: thr_met = gt_hi;
            default: thr_met = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // software registers with reset
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lth_r <= `ACR_THR_RST;
            uth_r <= `ACR_THR_RST;
            stpt_r <= `ACR_THR_RST;
            rpt_r <= 8'h00;
            prevh_r <= `ACR_PREVH_RST;
            ctrl_r <= `ACR_CTRL_RST;
            stat_r <= 3'h0;
            batch_new_r <= 1'b1;
        end
        else
        begin
            // byte-lane writes
            if (wr_lth)
                lth_r <= lth_m[15:0];
            if (wr_uth)
                uth_r <= uth_m[15:0];
            if (wr_stpt)
                stpt_r <= stpt_m[15:0];
            if (wr_rpt && pstrb[0])
                rpt_r <= pwdata[7:0];
            // control: software writes, engine done clears go; a
            // write that leaves lane 0 alone must not undo the clear
            if (wr_ctrl)
                ctrl_r <= ctrl_m[18:0];
            if (conv_done && !(wr_ctrl && pstrb[0]))
                ctrl_r[`ACR_CTRL_GO] <= 1'b0;
            // previous result upper byte at conversion start
            // both bytes sample the same source at the same edge
            if (conv_start)
                prevh_r <= previous_source_select ? fltr_r[15:8] : res_r[15:8];
            // lower and upper flags follow each check; sticky interrupt flag: hardware set wins over clear
            // a clear in the cycle of a new hit is lost, by intent
            if (check)
            begin
                stat_r[`ACR_STAT_LOWER_THRESHOLD_FLAG] <= lt_lo;
                stat_r[`ACR_STAT_UPPER_THRESHOLD_FLAG] <= gt_hi;
            end
            if (check && thr_met)
                stat_r[`ACR_STAT_TIF] <= 1'b1;
            else if (wr_stat && pstrb[0] && pwdata[`ACR_STAT_TIF])
                stat_r[`ACR_STAT_TIF] <= 1'b0;
            // batch boundary for averaging modes
            if (conv_done)
                batch_new_r <= check;
        end
    end

    // ------------------------------------------------------------
    // registers that keep contents across system reset
    // ------------------------------------------------------------
    // no reset branch: these survive presetn and come up unknown
    // at power-on; a check in average, burst or low-pass mode clears the counter, a software write loads it
    always @(posedge pclk)
    begin
        // repeat counter
        // a hit at done clears it, the next trigger counts one
        if (wr_cnt && pstrb[0])
            cnt_r <= pwdata[7:0];
        else if (conv_done && rep_mode && cnt_hit)
            cnt_r <= 8'h00;
        else if (conv_start)
            cnt_r <= cnt_r + 8'h01;
        // previous result lower byte
        if (conv_start)
            prevl_r <= previous_source_select ? fltr_r[7:0] : res_r[7:0];
        // result: engine sample or software write
        if (conv_done)
            res_r <= res_algn;
        else if (wr_res)
            res_r <= res_m[15:0];
        // accumulator: engine or idle-time software write
        // the engine wins in a shared cycle; lane 2 keeps only
        // bits 17:16, the sign copies above are made on read
        if (conv_done)
            acc_r <= acc_nxt;
        else if (wr_acc)
        begin
            if (pstrb[0])
                acc_r[7:0] <= pwdata[7:0];
            if (pstrb[1])
                acc_r[15:8] <= pwdata[15:8];
            if (pstrb[2])
                acc_r[17:16] <= pwdata[17:16];
        end
        // filter updated only by computation
        // basic mode leaves the last filter value untouched
        if (conv_done && md != `ACR_MD_BASIC)
            fltr_r <= fltr_nxt;
        // error updated at each threshold check
        if (check)
            err_r <= err_nxt;
    end

    // ------------------------------------------------------------
    // read data, captured in the setup phase
    // ------------------------------------------------------------
    reg [31:0] rd_mux; // read selection

    always @*
    begin
        case (idx)
            `ACR_IDX_LTH: rd_mux = {16'h0000, lth_r};
            `ACR_IDX_UTH: rd_mux = {16'h0000, uth_r};
            `ACR_IDX_ERR: rd_mux = {16'h0000, err_r};
            `ACR_IDX_STPT: rd_mux = {16'h0000, stpt_r};
            `ACR_IDX_FLTR: rd_mux = {16'h0000, fltr_r};
            // sign copies in bits 23:18, zeros above
            `ACR_IDX_ACC: rd_mux = {8'h00, {6{acc_r[17]}}, acc_r};
            `ACR_IDX_CNT: rd_mux = {24'h000000, cnt_r};
            `ACR_IDX_RPT: rd_mux = {24'h000000, rpt_r};
            `ACR_IDX_PREV: rd_mux = {16'h0000, prevh_r, prevl_r};
            `ACR_IDX_RES: rd_mux = {16'h0000, res_r};
            `ACR_IDX_CTRL: rd_mux = {13'h0000, ctrl_r};
            `ACR_IDX_STAT: rd_mux = {29'h00000000, stat_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // load read data at setup so it is stable in access
    // writes leave prdata alone, so it shows the last read until
    // the next read setup
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    // go and the interrupt flag leave the block straight from flops
    assign conv_go = go;
    assign threshold_interrupt_flag = stat_r[`ACR_STAT_TIF];

endmodule // acr_regs

/* File: verification/acr_regs_chk.sv */
/*
 * Checker for the converter computation register block, bound to the
 * top module ports.
 * Assumes the zero-wait APB slave and the pulse engine interface.
 */
`include "acr_map.vh"

module acr_regs_chk #(
    parameter SAMPLE_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire conv_start,
    input wire conv_done,
    input wire [SAMPLE_W-1:0] conv_sample,
    input wire conv_go,
    input wire threshold_interrupt_flag
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    wire acc_ph = psel && penable; // access phase
    wire [11:0] ca = {`ACR_IDX_CTRL, 2'b00}; // control address
    wire [11:0] sa = {`ACR_IDX_STAT, 2'b00}; // status address
    wire ctrl_wr = acc_ph && pwrite && paddr == ca && pstrb[0];
    wire tif_clr = acc_ph && pwrite && paddr == sa && pstrb[0] && pwdata[2];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_ready_zero_wait: assert property (pready == acc_ph)
        else $error("pready not equal to access phase");
    a_slverr_in_access: assert property (pslverr |-> acc_ph)
        else $error("pslverr outside access phase");
    a_unmapped_zero_data: assert property (acc_ph && pslverr && !pwrite
        |-> prdata == 32'h00000000)
        else $error("unmapped read data not zero");
    a_mapped_no_err: assert property (acc_ph && (paddr == 12'h230
        || paddr == 12'h274) |-> !pslverr)
        else $error("mapped register refused");
    a_rdata_hold: assert property ($changed(prdata)
        |-> $past(psel && !penable && !pwrite))
        else $error("read data changed outside read setup");
    a_go_hw_clear: assert property (
        conv_go && conv_done && !ctrl_wr |=> !conv_go)
        else $error("go not cleared after done");
    a_go_sw_set: assert property ($rose(conv_go)
        |-> $past(ctrl_wr && pwdata[0]))
        else $error("go rose without a control write");
    a_flag_rise_done: assert property (
        $rose(threshold_interrupt_flag) |-> $past(conv_done))
        else $error("interrupt flag rose without done");
    a_flag_sticky: assert property (
        threshold_interrupt_flag && !tif_clr |=> threshold_interrupt_flag)
        else $error("interrupt flag lost without clear");
    c_flag_rise: cover property ($rose(threshold_interrupt_flag));
    c_go_fall: cover property ($fell(conv_go));
    c_slverr: cover property (pslverr);
endmodule // acr_regs_chk

/* File: verification/tb_top.sv */
/*
 * Directed testbench of the converter computation register block.
 * Assumes the zero-wait APB slave and pulse engine of the design.
 */
`include "acr_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected at %0t: got %h exp %h", \
    $time, g, e); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // stimulus signals
    // ----------------------------------------------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, conv_go, tif;
    logic conv_start = 0, conv_done = 0;
    logic [11:0] conv_sample = 0;
    logic last_err; // slave error of last transfer
    logic [31:0] r;
    int n_mismatch = 0, samples_checked = 0;
    always #10 pclk = ~pclk; // 50 MHz

    acr_regs #(.SAMPLE_W(12)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done),
        .conv_sample(conv_sample), .conv_go(conv_go),
        .threshold_interrupt_flag(tif));

    // ----------------------------------------------------------------
    // bus and engine tasks
    // ----------------------------------------------------------------
    function automatic logic [11:0] ad(input logic [9:0] i);
        return {i, 2'b00};
    endfunction
    function automatic logic [31:0] cw(input logic go, fmt, ps,
        input logic [2:0] md, shift_select, error_select_a, threshold_mode_select);
        return (go << `ACR_CTRL_GO) | (fmt << `ACR_CTRL_FMT)
            | (ps << `ACR_CTRL_PREVIOUS_SOURCE_SELECT) | (md << `ACR_CTRL_MD_LO)
            | (shift_select << `ACR_CTRL_CRS_LO) | (error_select_a << `ACR_CTRL_ERROR_SELECT_A_LO)
            | (threshold_mode_select << `ACR_CTRL_TMD_LO);
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w;
        paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_mismatch++;
            summarize();
        end
        r = prdata;
        last_err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        apb(1, ad(i), d, 4'hF);
    endtask
    task automatic rd(input logic [9:0] i);
        apb(0, ad(i), 32'h0, 4'h0);
    endtask
    task automatic pulse_start;
        @(posedge pclk) conv_start <= 1;
        @(posedge pclk) conv_start <= 0;
    endtask
    task automatic pulse_done(input logic [11:0] s);
        @(posedge pclk) begin conv_done <= 1; conv_sample <= s; end
        @(posedge pclk) conv_done <= 0;
        @(posedge pclk);
    endtask
    task automatic conv(input logic [11:0] s);
        pulse_start();
        pulse_done(s);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values;
        rd(`ACR_IDX_LTH); `CHK(r, 32'h0)
        rd(`ACR_IDX_UTH); `CHK(r, 32'h0)
        rd(`ACR_IDX_STPT); `CHK(r, 32'h0)
        rd(`ACR_IDX_PREV); `CHK(r[15:8], `ACR_PREVH_RST)
        rd(10'h3FF); `CHK(r, 32'h0)
        `CHK(last_err, 1'b1)
        wr(`ACR_IDX_LTH, 32'h0000ABCD);
        apb(1, ad(`ACR_IDX_LTH), 32'h00001200, 4'h2);
        rd(`ACR_IDX_LTH); `CHK(r[15:0], 16'h12CD)
        $display("test reset_values done");
    endtask
    task automatic t_result_format;
        wr(`ACR_IDX_CTRL, cw(0, 1, 0, `ACR_MD_BASIC, 0, 0, 0));
        conv(12'hABC);
        rd(`ACR_IDX_RES); `CHK(r[15:0], 16'h0ABC)
        wr(`ACR_IDX_CTRL, cw(0, 0, 0, `ACR_MD_BASIC, 0, 0, 0));
        conv(12'h5A3);
        rd(`ACR_IDX_RES); `CHK(r[15:0], 16'h5A30)
        pulse_start();
        rd(`ACR_IDX_PREV); `CHK(r[15:0], 16'h5A30)
        pulse_done(12'h001);
        wr(`ACR_IDX_RES, 32'h00001234);
        rd(`ACR_IDX_RES); `CHK(r[15:0], 16'h1234)
        $display("test result_format done");
    endtask
    task automatic t_threshold_modes;
        logic [7:0] exp_tif;
        exp_tif = 8'hB2; // error -8 lies below lower -5
        wr(`ACR_IDX_STPT, 32'h00000100);
        wr(`ACR_IDX_LTH, 32'h0000FFFB);
        wr(`ACR_IDX_UTH, 32'h00000005);
        for (int m = 0; m < 8; m++)
        begin
            wr(`ACR_IDX_CTRL, cw(0, 1, 0, `ACR_MD_BASIC, 0,
                `ACR_ERROR_SELECT_A_RES_STPT, m[2:0]));
            wr(`ACR_IDX_STAT, 32'h7);
            conv(12'h0F8);
            rd(`ACR_IDX_ERR); `CHK(r[15:0], 16'hFFF8)
            rd(`ACR_IDX_STAT);
            `CHK(r[1:0], 2'b01)
            `CHK(r[2], exp_tif[m])
            `CHK(tif, exp_tif[m])
        end
        $display("test threshold_modes done");
    endtask
    task automatic t_accumulate;
        wr(`ACR_IDX_CTRL, cw(0, 1, 0, `ACR_MD_ACC, 2, 0, 0));
        wr(`ACR_IDX_ACC, 32'h0003FFF0);
        rd(`ACR_IDX_ACC); `CHK(r[23:0], 24'hFFFFF0)
        wr(`ACR_IDX_CTRL, cw(1, 1, 0, `ACR_MD_ACC, 2, `ACR_ERROR_SELECT_A_FLTR_STPT, 0));
        wr(`ACR_IDX_ACC, 32'h00000000);
        rd(`ACR_IDX_ACC); `CHK(r[23:0], 24'hFFFFF0)
        conv(12'h040);
        `CHK(conv_go, 1'b0)
        rd(`ACR_IDX_FLTR); `CHK(r[15:0], 16'h000C)
        // filter 12 minus setpoint 256 left from the threshold test
        rd(`ACR_IDX_ERR); `CHK(r[15:0], 16'hFF0C)
        wr(`ACR_IDX_FLTR, 32'h00005555);
        rd(`ACR_IDX_FLTR); `CHK(r[15:0], 16'h000C)
        $display("test accumulate done");
    endtask
    task automatic t_repeat_lpf;
        wr(`ACR_IDX_CTRL, cw(0, 1, 0, `ACR_MD_AVG, 0, 0, `ACR_TMD_ALWAYS));
        wr(`ACR_IDX_RPT, 32'h3);
        wr(`ACR_IDX_CNT, 32'h0);
        wr(`ACR_IDX_STAT, 32'h7);
        for (int k = 1; k <= 3; k++)
        begin
            pulse_start();
            rd(`ACR_IDX_CNT); `CHK(r[7:0], k[7:0])
            pulse_done(12'h010);
            `CHK(tif, k == 3)
        end
        rd(`ACR_IDX_CNT); `CHK(r[7:0], 8'h00)
        wr(`ACR_IDX_CTRL, cw(0, 1, 0, `ACR_MD_LPF, 1, 0, 0));
        wr(`ACR_IDX_ACC, 32'h0);
        conv(12'h100);
        rd(`ACR_IDX_FLTR); `CHK(r[15:0], 16'h0080)
        wr(`ACR_IDX_CTRL, cw(0, 1, 1, `ACR_MD_LPF, 1, 0, 0));
        pulse_start();
        rd(`ACR_IDX_PREV); `CHK(r[15:0], 16'h0080)
        pulse_done(12'h100);
        $display("test repeat_lpf done");
    endtask
    task automatic t_warm_reset;
        wr(`ACR_IDX_CNT, 32'h5);
        wr(`ACR_IDX_RES, 32'h00001234);
        wr(`ACR_IDX_LTH, 32'h00000077);
        @(posedge pclk) presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rd(`ACR_IDX_CNT); `CHK(r[7:0], 8'h05)
        rd(`ACR_IDX_RES); `CHK(r[15:0], 16'h1234)
        rd(`ACR_IDX_LTH); `CHK(r[15:0], `ACR_THR_RST)
        $display("test warm_reset done");
    endtask

    // ----------------------------------------------------------------
    // verdict and main sequence
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_reset_values();
        t_result_format();
        t_threshold_modes();
        t_accumulate();
        t_repeat_lpf();
        t_warm_reset();
        summarize();
    end
endmodule // tb_top

bind acr_regs acr_regs_chk #(.SAMPLE_W(SAMPLE_W)) chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
    .conv_done(conv_done), .conv_sample(conv_sample), .conv_go(conv_go),
    .threshold_interrupt_flag(threshold_interrupt_flag));
